// ==== rtl/memory_map_exception_vectors_pkg.sv ====
// constants and types for the address decoder and exception vector unit
package memory_map_exception_vectors_pkg;

    localparam int ADDR_W = 17;
    localparam int NUM_SRC = 19;
    localparam int IDX_W = 5;

    // memory regions
    localparam logic [16:0] ROM_LO_START = 17'h00000;
    localparam logic [16:0] ROM_LO_END = 17'h0CFFF;
    localparam logic [16:0] ROM_HI_START = 17'h10000;
    localparam logic [16:0] ROM_HI_END = 17'h1FFFF;
    localparam logic [16:0] RAM_START = 17'h0D800;
    localparam logic [16:0] RAM_END = 17'h0F7FF;
    localparam logic [16:0] DISP_START = 17'h0F800;
    localparam logic [16:0] DISP_END = 17'h0FD57;
    localparam logic [16:0] IO_START = 17'h0FF00;
    localparam logic [16:0] IO_END = 17'h0FFFF;
    localparam logic [16:0] IO_UNMASK_A = 17'h0FF00;
    localparam logic [16:0] IO_UNMASK_B = 17'h0FF01;

    // vector table
    localparam logic [16:0] RESET_VEC = 17'h00000;
    localparam logic [16:0] FIRST_SRC_VEC = 17'h00002;
    localparam logic [16:0] VEC_TABLE_END = 17'h00027;
    localparam logic [16:0] RESERVED_VEC = 17'h00028;
    localparam logic [16:0] SW_VEC_START = 17'h0002A;
    localparam logic [16:0] SW_VEC_END = 17'h000FF;

    // source indices, fixed order equals vector order
    localparam logic [4:0] SRC_ZERO_DIV = 5'h00;
    localparam logic [4:0] SRC_NMI = 5'h01;

    // effective levels of the two unmaskable-by-level sources
    localparam logic [2:0] LVL_ZERO_DIV = 3'h5;
    localparam logic [2:0] LVL_NMI = 3'h4;

    typedef struct packed {
        logic rom;
        logic ram;
        logic disp;
        logic io;
        logic unmapped;
    } mem_sel_t;

    typedef struct packed {
        logic load;
        logic [15:0] addr;
    } handler_t;

    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_VEC_LO = 6'h02,
        ST_VEC_HI = 6'h04,
        ST_JUMP = 6'h08,
        ST_RUN = 6'h10,
        ST_PUSH = 6'h20
    } exc_state_t;

endpackage

// ==== rtl/memory_map_exception_vectors.sv ====
// address decoder, reset sources and exception vector sequencer
`timescale 1ns/1ns
module memory_map_exception_vectors #(
    parameter logic [3:0] KEY_RESET_MASK = 4'h0
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic reset_pin_n_i,
    input wire logic [3:0] key_group_low_n_i,
    input wire logic supply_voltage_detector_i,
    input wire logic [16:0] cpu_addr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_wr_i,
    input wire logic [18:0] irq_req_i,
    input wire logic [37:0] irq_level_i,
    input wire logic [1:0] cpu_int_level_i,
    input wire logic cpu_accept_i,
    input wire logic [7:0] vec_data_i,
    output memory_map_exception_vectors_pkg::mem_sel_t mem_sel_o,
    output logic cpu_reset_o,
    output logic vec_rd_o,
    output logic [16:0] vec_addr_o,
    output logic stack_push_o,
    output memory_map_exception_vectors_pkg::handler_t handler_o,
    output logic [18:0] irq_ack_o,
    output logic int_unmasked_o,
    output logic customized_condition_flag_o
);

    // address decode, one region at most
    function automatic memory_map_exception_vectors_pkg::mem_sel_t decode(
        input logic [16:0] a
    );
        memory_map_exception_vectors_pkg::mem_sel_t s;
        s = '0;
        s.rom = (a <= memory_map_exception_vectors_pkg::ROM_LO_END) ||
            (a >= memory_map_exception_vectors_pkg::ROM_HI_START);
        s.ram = (a >= memory_map_exception_vectors_pkg::RAM_START) &&
            (a <= memory_map_exception_vectors_pkg::RAM_END);
        s.disp = (a >= memory_map_exception_vectors_pkg::DISP_START) &&
            (a <= memory_map_exception_vectors_pkg::DISP_END);
        s.io = (a >= memory_map_exception_vectors_pkg::IO_START) &&
            (a <= memory_map_exception_vectors_pkg::IO_END);
        s.unmapped = !(s.rom || s.ram || s.disp || s.io);
        return s;
    endfunction

    // vector address of a source index, never past the fixed table
    function automatic logic [16:0] vec_of(input logic [4:0] idx);
        return memory_map_exception_vectors_pkg::FIRST_SRC_VEC +
            {11'h000, idx, 1'b0};
    endfunction

    // effective level of a source for arbitration
    function automatic logic [2:0] level_of(
        input logic [4:0] idx,
        input logic [37:0] lv
    );
        logic [2:0] l;
        l = {1'b0, lv[{idx, 1'b0} +: 2]};
        if (idx == memory_map_exception_vectors_pkg::SRC_ZERO_DIV) begin
            l = memory_map_exception_vectors_pkg::LVL_ZERO_DIV;
        end else if (idx == memory_map_exception_vectors_pkg::SRC_NMI) begin
            l = memory_map_exception_vectors_pkg::LVL_NMI;
        end
        return l;
    endfunction

    memory_map_exception_vectors_pkg::exc_state_t state_reg;
    memory_map_exception_vectors_pkg::mem_sel_t sel_reg;
    memory_map_exception_vectors_pkg::handler_t handler_reg;
    logic pin_meta_reg;
    logic pin_sync_n_reg;
    logic [3:0] key_meta_reg;
    logic [3:0] key_sync_n_reg;
    logic svd_meta_reg;
    logic svd_sync_reg;
    logic reset_active;
    logic cpu_reset_reg;
    logic vec_rd_reg;
    logic [16:0] vec_addr_reg;
    logic [7:0] vec_lo_reg;
    logic push_reg;
    logic [18:0] ack_reg;
    logic seen_a_reg;
    logic seen_b_reg;
    logic unmasked_reg;
    logic cc_reg;
    logic [18:0] eligible;
    logic pend_valid;
    logic [4:0] pend_idx;
    logic [2:0] pend_lvl;

    // two-flop synchronisers for the external reset sources
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pin_meta_reg <= 1'b0;
            pin_sync_n_reg <= 1'b0;
            key_meta_reg <= 4'hF;
            key_sync_n_reg <= 4'hF;
            svd_meta_reg <= 1'b0;
            svd_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= reset_pin_n_i;
            pin_sync_n_reg <= pin_meta_reg;
            key_meta_reg <= key_group_low_n_i;
            key_sync_n_reg <= key_meta_reg;
            svd_meta_reg <= supply_voltage_detector_i;
            svd_sync_reg <= svd_meta_reg;
        end
    end

    // any active source holds the initial reset
    assign reset_active = !pin_sync_n_reg || svd_sync_reg ||
        ((KEY_RESET_MASK != 4'h0) &&
        ((key_sync_n_reg & KEY_RESET_MASK) == 4'h0));

    // registered region select for each core access
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sel_reg <= '0;
        end else if (cpu_rd_i || cpu_wr_i) begin
            sel_reg <= decode(cpu_addr_i);
        end else begin
            sel_reg <= '0;
        end
    end

    // interrupt mask release after both setup writes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || reset_active) begin
            seen_a_reg <= 1'b0;
            seen_b_reg <= 1'b0;
            unmasked_reg <= 1'b0;
        end else begin
            if (cpu_wr_i &&
                cpu_addr_i == memory_map_exception_vectors_pkg::IO_UNMASK_A
            ) begin
                seen_a_reg <= 1'b1;
            end
            if (cpu_wr_i &&
                cpu_addr_i == memory_map_exception_vectors_pkg::IO_UNMASK_B
            ) begin
                seen_b_reg <= 1'b1;
            end
            unmasked_reg <= seen_a_reg && seen_b_reg;
        end
    end

    // sources allowed to compete this cycle
    always_comb begin
        eligible = irq_req_i & {19{unmasked_reg}};
        eligible[0] = irq_req_i[0];
        for (int i = 2; i < memory_map_exception_vectors_pkg::NUM_SRC;
            i++) begin
            if (irq_level_i[2*i +: 2] <= cpu_int_level_i) begin
                eligible[i] = 1'b0;
            end
        end
    end

    // highest level wins, lower index breaks ties
    always_comb begin
        pend_valid = 1'b0;
        pend_idx = 5'h00;
        pend_lvl = 3'h0;
        for (int i = memory_map_exception_vectors_pkg::NUM_SRC - 1; i >= 0;
            i--) begin
            if (eligible[i] &&
                (!pend_valid || level_of(5'(i), irq_level_i) >= pend_lvl)
            ) begin
                pend_valid = 1'b1;
                pend_idx = 5'(i);
                pend_lvl = level_of(5'(i), irq_level_i);
            end
        end
    end

    // exception sequencer
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || reset_active) begin
            state_reg <= memory_map_exception_vectors_pkg::ST_RESET;
            cpu_reset_reg <= 1'b1;
            vec_rd_reg <= 1'b0;
            vec_addr_reg <= memory_map_exception_vectors_pkg::RESET_VEC;
            vec_lo_reg <= 8'h00;
            push_reg <= 1'b0;
            ack_reg <= '0;
            handler_reg <= '0;
        end else begin
            handler_reg.load <= 1'b0;
            push_reg <= 1'b0;
            ack_reg <= '0;
            case (state_reg)
                memory_map_exception_vectors_pkg::ST_RESET: begin
                    cpu_reset_reg <= 1'b0;
                    vec_rd_reg <= 1'b1;
                    vec_addr_reg <= memory_map_exception_vectors_pkg::RESET_VEC;
                    state_reg <= memory_map_exception_vectors_pkg::ST_VEC_LO;
                end
                memory_map_exception_vectors_pkg::ST_VEC_LO: begin
                    vec_addr_reg <= vec_addr_reg + 17'h00001;
                    state_reg <= memory_map_exception_vectors_pkg::ST_VEC_HI;
                end
                memory_map_exception_vectors_pkg::ST_VEC_HI: begin
                    vec_lo_reg <= vec_data_i; // low byte at even address
                    vec_rd_reg <= 1'b0;
                    state_reg <= memory_map_exception_vectors_pkg::ST_JUMP;
                end
                memory_map_exception_vectors_pkg::ST_JUMP: begin
                    handler_reg.load <= 1'b1;
                    handler_reg.addr <= {vec_data_i, vec_lo_reg};
                    state_reg <= memory_map_exception_vectors_pkg::ST_RUN;
                end
                memory_map_exception_vectors_pkg::ST_RUN: begin
                    if (cpu_accept_i && pend_valid) begin
                        push_reg <= 1'b1;
                        ack_reg[pend_idx] <= 1'b1;
                        vec_addr_reg <= vec_of(pend_idx);
                        state_reg <= memory_map_exception_vectors_pkg::ST_PUSH;
                    end
                end
                memory_map_exception_vectors_pkg::ST_PUSH: begin
                    vec_rd_reg <= 1'b1;
                    state_reg <= memory_map_exception_vectors_pkg::ST_VEC_LO;
                end
                default: begin
                    state_reg <= memory_map_exception_vectors_pkg::ST_RESET;
                end
            endcase
        end
    end

    // the customized condition flag stays permanently low
    always_ff @(posedge clk_sys_i) begin
        cc_reg <= 1'b0;
    end

    // outputs straight from flops
    assign mem_sel_o = sel_reg;
    assign cpu_reset_o = cpu_reset_reg;
    assign vec_rd_o = vec_rd_reg;
    assign vec_addr_o = vec_addr_reg;
    assign stack_push_o = push_reg;
    assign handler_o = handler_reg;
    assign irq_ack_o = ack_reg;
    assign int_unmasked_o = unmasked_reg;
    assign customized_condition_flag_o = cc_reg;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    // decode checks
    a_sel_onehot: assert property ($onehot0(mem_sel_o))
        else $error("more than one region selected");
    a_rom_select: assert property (
        cpu_rd_i && (cpu_addr_i <=
        memory_map_exception_vectors_pkg::ROM_LO_END || cpu_addr_i[16])
        |=> mem_sel_o.rom)
        else $error("rom not selected");
    a_ram_select: assert property (
        (cpu_rd_i || cpu_wr_i) &&
        cpu_addr_i >= memory_map_exception_vectors_pkg::RAM_START &&
        cpu_addr_i <= memory_map_exception_vectors_pkg::RAM_END
        |=> mem_sel_o.ram)
        else $error("ram not selected");
    a_io_select: assert property (
        cpu_wr_i &&
        cpu_addr_i >= memory_map_exception_vectors_pkg::IO_START &&
        !cpu_addr_i[16] |=> mem_sel_o.io)
        else $error("io window not selected");
    a_disp_select: assert property (
        cpu_rd_i &&
        cpu_addr_i >= memory_map_exception_vectors_pkg::DISP_START &&
        cpu_addr_i <= memory_map_exception_vectors_pkg::DISP_END
        |=> mem_sel_o.disp)
        else $error("display memory not selected");
    a_gap_unmapped: assert property (
        cpu_rd_i &&
        cpu_addr_i > memory_map_exception_vectors_pkg::ROM_LO_END &&
        cpu_addr_i < memory_map_exception_vectors_pkg::RAM_START
        |=> mem_sel_o.unmapped && !mem_sel_o.rom)
        else $error("gap address selected a memory");
    a_io_gap_unmapped: assert property (
        (cpu_rd_i || cpu_wr_i) &&
        cpu_addr_i > memory_map_exception_vectors_pkg::DISP_END &&
        cpu_addr_i < memory_map_exception_vectors_pkg::IO_START
        |=> mem_sel_o.unmapped)
        else $error("gap below io window selected a memory");

    // vector sequencing checks
    a_vec_in_table: assert property (
        vec_rd_o |-> vec_addr_o <=
        memory_map_exception_vectors_pkg::VEC_TABLE_END &&
        vec_addr_o != memory_map_exception_vectors_pkg::RESERVED_VEC)
        else $error("vector read outside fixed table");
    a_reset_vector: assert property (
        $fell(cpu_reset_o) |-> vec_rd_o &&
        vec_addr_o == memory_map_exception_vectors_pkg::RESET_VEC
        ##1 vec_rd_o ##2 handler_o.load)
        else $error("reset release did not fetch reset vector");
    a_push_then_fetch: assert property (
        stack_push_o |-> !vec_rd_o ##1 vec_rd_o ##1 vec_rd_o
        ##2 handler_o.load)
        else $error("push not followed by vector fetch");
    a_handler_bytes: assert property (
        handler_o.load |->
        handler_o.addr == {$past(vec_data_i), $past(vec_data_i, 2)})
        else $error("handler address byte order wrong");

    // interrupt arbitration and masking checks
    a_zero_div_first: assert property (
        stack_push_o && $past(irq_req_i[0]) |-> irq_ack_o[0])
        else $error("zero division not served first");
    a_ack_with_push: assert property (
        irq_ack_o != '0 |-> stack_push_o && $onehot(irq_ack_o))
        else $error("acknowledge without a single push");
    a_level_refused: assert property (
        state_reg == memory_map_exception_vectors_pkg::ST_RUN &&
        cpu_accept_i && pend_valid &&
        pend_idx > memory_map_exception_vectors_pkg::SRC_NMI
        |-> pend_lvl > {1'b0, cpu_int_level_i})
        else $error("source taken at or below the core level");
    a_nmi_over_level: assert property (
        state_reg == memory_map_exception_vectors_pkg::ST_RUN &&
        irq_req_i[1] && !irq_req_i[0] && int_unmasked_o
        |-> pend_valid &&
        pend_idx == memory_map_exception_vectors_pkg::SRC_NMI)
        else $error("nmi lost arbitration");
    a_mask_until_setup: assert property (
        !int_unmasked_o |=> !irq_ack_o[1])
        else $error("nmi taken while masked");
    a_unmask_cleared: assert property (
        reset_active |=> !int_unmasked_o)
        else $error("interrupt mask not restored by reset");

    // reset and flag checks
    a_cc_unused: assert property (!customized_condition_flag_o)
        else $error("customized condition flag driven");
    a_reset_hold: assert property (reset_active |=> cpu_reset_o)
        else $error("reset source not holding reset");
    a_pin_sync: assert property (
        $fell(reset_pin_n_i) ##1 !reset_pin_n_i |-> ##[1:2] cpu_reset_o)
        else $error("reset pin not seen after synchroniser");

    // main scenarios worth seeing at least once
    c_reset_release: cover property ($fell(cpu_reset_o));
    c_nmi_taken: cover property (irq_ack_o[1]);
    c_timer_taken: cover property (irq_ack_o[2]);
    c_zero_div_taken: cover property (irq_ack_o[0]);
    c_key_reset: cover property (pin_sync_n_reg && reset_active);

endmodule

// ==== tb/vector_rom_model.sv ====
// program memory model answering vector reads from the exception unit
`timescale 1ns/1ns
module vector_rom_model (
    input wire logic clk_sys_i,
    input wire logic vec_rd_i,
    input wire logic [16:0] vec_addr_i,
    output logic [7:0] vec_data_o
);
    // byte at a vector address: even byte is the low half of the handler
    function automatic logic [7:0] rom_byte(input logic [16:0] a);
        if (a == 17'h00028 || a == 17'h00029) begin
            return 8'hFF; // reserved entry holds no handler
        end
        return a[0] ? {2'b11, a[6:1]} : (a[7:0] ^ 8'h3C);
    endfunction

    initial vec_data_o = 8'h00;

    // data follows a read cycle by one clock; an idle bus keeps toggling
    always @(posedge clk_sys_i) begin
        if (vec_rd_i) begin
            vec_data_o <= rom_byte(vec_addr_i);
        end else begin
            vec_data_o <= ~vec_data_o;
        end
    end
endmodule

// ==== tb/memory_map_exception_vectors_test.sv ====
// self-checking bench for the address decoder and exception vector unit
`timescale 1ns/1ns
module memory_map_exception_vectors_test;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic reset_pin_n_i = 1'b0;
    logic [3:0] key_group_low_n_i = 4'hF;
    logic supply_voltage_detector_i = 1'b0;
    logic [16:0] cpu_addr_i = 17'h00000;
    logic cpu_rd_i = 1'b0;
    logic cpu_wr_i = 1'b0;
    logic [18:0] irq_req_i = 19'h00000;
    logic [37:0] irq_level_i = 38'h0;
    logic [1:0] cpu_int_level_i = 2'h0;
    logic cpu_accept_i = 1'b0;
    logic [7:0] vec_data_i;
    memory_map_exception_vectors_pkg::mem_sel_t mem_sel_o;
    memory_map_exception_vectors_pkg::handler_t handler_o;
    logic cpu_reset_o;
    logic vec_rd_o;
    logic [16:0] vec_addr_o;
    logic stack_push_o;
    logic [18:0] irq_ack_o;
    logic int_unmasked_o;
    logic customized_condition_flag_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    // decode table: address and expected select {rom,ram,disp,io,unmapped}
    logic [16:0] dec_addr [14] = '{17'h00000, 17'h0CFFF, 17'h0D000,
        17'h0D7FF, 17'h0D800, 17'h0F7FF, 17'h0F800, 17'h0FD57, 17'h0FD58,
        17'h0FEFF, 17'h0FF00, 17'h0FFFF, 17'h10000, 17'h1FFFF};
    logic [4:0] dec_sel [14] = '{5'h10, 5'h10, 5'h01, 5'h01, 5'h08, 5'h08,
        5'h04, 5'h04, 5'h01, 5'h01, 5'h02, 5'h02, 5'h10, 5'h10};

    always #10 clk_sys_i = ~clk_sys_i;

    memory_map_exception_vectors #(.KEY_RESET_MASK(4'h3))
        i_memory_map_exception_vectors (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n_i),
        .key_group_low_n_i(key_group_low_n_i),
        .supply_voltage_detector_i(supply_voltage_detector_i),
        .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i), .cpu_wr_i(cpu_wr_i),
        .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
        .cpu_int_level_i(cpu_int_level_i), .cpu_accept_i(cpu_accept_i),
        .vec_data_i(vec_data_i), .mem_sel_o(mem_sel_o),
        .cpu_reset_o(cpu_reset_o), .vec_rd_o(vec_rd_o),
        .vec_addr_o(vec_addr_o), .stack_push_o(stack_push_o),
        .handler_o(handler_o), .irq_ack_o(irq_ack_o),
        .int_unmasked_o(int_unmasked_o),
        .customized_condition_flag_o(customized_condition_flag_o));

    vector_rom_model i_vector_rom_model (.clk_sys_i(clk_sys_i),
        .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
        .vec_data_o(vec_data_i));

    task automatic results();
        $display("Checks: %0d, mismatches: %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            results();
        end
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t ns: seen %0h expected %0h", $time, seen,
                exp);
        end
    endtask

    // handler address the memory model stores for a vector
    function automatic logic [15:0] handler_of(input logic [16:0] v);
        return {2'b11, v[6:1], v[7:0] ^ 8'h3C};
    endfunction

    task automatic wait_load(input logic [16:0] v);
        int n = 0;
        while (handler_o.load !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        chk(handler_o.load, 1'b1);
        chk(handler_o.addr, handler_of(v));
    endtask

    // waits for release of core reset and follows the reset vector fetch
    task automatic boot();
        int n = 0;
        while (cpu_reset_o !== 1'b0 && n < 20) begin
            step();
            n++;
        end
        chk(vec_rd_o, 1'b1);
        chk(vec_addr_o, 17'h00000);
        chk(stack_push_o, 1'b0);
        chk(int_unmasked_o, 1'b0);
        wait_load(17'h00000);
    endtask

    task automatic decode();
        for (int i = 0; i < 14; i++) begin
            cpu_addr_i = dec_addr[i];
            cpu_rd_i = 1'b1;
            step();
            cpu_rd_i = 1'b0;
            chk(mem_sel_o, dec_sel[i]);
            step();
            chk(mem_sel_o, 5'h00);
        end
    endtask

    // accepts one exception and follows its vector fetch
    task automatic take(input int idx, input logic [16:0] v);
        int n = 0;
        logic [18:0] ack;
        logic [16:0] va;
        cpu_accept_i = 1'b1;
        while (stack_push_o !== 1'b1 && n < 20) begin
            step();
            n++;
        end
        ack = irq_ack_o;
        va = vec_addr_o;
        cpu_accept_i = 1'b0;
        irq_req_i = 19'h00000;
        chk(stack_push_o, 1'b1);
        chk(ack, 19'h00001 << idx);
        chk(va, v);
        wait_load(v);
    endtask

    // the core offers a boundary for ten cycles; nothing may be taken
    task automatic refuse();
        int seen = 0;
        cpu_accept_i = 1'b1;
        repeat (10) begin
            step();
            if (stack_push_o === 1'b1) begin
                seen++;
            end
        end
        cpu_accept_i = 1'b0;
        irq_req_i = 19'h00000;
        chk(seen, 0);
    endtask

    task automatic unmask();
        int n = 0;
        cpu_addr_i = 17'h0FF00;
        cpu_wr_i = 1'b1;
        step();
        cpu_wr_i = 1'b0;
        chk(mem_sel_o, 5'h02);
        step(3);
        chk(int_unmasked_o, 1'b0);
        cpu_addr_i = 17'h0FF01;
        cpu_wr_i = 1'b1;
        step();
        cpu_wr_i = 1'b0;
        while (int_unmasked_o !== 1'b1 && n < 6) begin
            step();
            n++;
        end
        chk(int_unmasked_o, 1'b1);
    endtask

    // one reset source is raised, held, then released
    task automatic src_reset(input int which);
        case (which)
            0: reset_pin_n_i = 1'b0;
            1: supply_voltage_detector_i = 1'b1;
            default: key_group_low_n_i = 4'hC;
        endcase
        step(6);
        chk(cpu_reset_o, 1'b1);
        reset_pin_n_i = 1'b1;
        supply_voltage_detector_i = 1'b0;
        key_group_low_n_i = 4'hF;
        step();
        chk(cpu_reset_o, 1'b1);
        boot();
    endtask

    initial begin
        step(5);
        chk(cpu_reset_o, 1'b1);
        step(5);
        rst_i = 1'b0;
        reset_pin_n_i = 1'b1;
        chk(customized_condition_flag_o, 1'b0);
        boot();
        decode();
        irq_level_i = {19{2'h3}};
        irq_req_i = 19'h00006;
        refuse();
        unmask();
        for (int i = 1; i < 19; i++) begin
            irq_req_i = 19'h00001 << i;
            take(i, 17'(2 + 2 * i));
        end
        irq_req_i = 19'h7FFFF;
        take(0, 17'h00002);
        cpu_int_level_i = 2'h3;
        irq_req_i = 19'h7FFFC;
        refuse();
        step();
        irq_req_i = 19'h00002;
        take(1, 17'h00004);
        irq_req_i = 19'h00001;
        take(0, 17'h00002);
        cpu_int_level_i = 2'h0;
        irq_level_i = {2'h3, {18{2'h1}}};
        irq_req_i = 19'h7FFFC;
        take(18, 17'h00026);
        irq_level_i = {19{2'h2}};
        irq_req_i = 19'h00220;
        take(5, 17'h0000C);
        key_group_low_n_i = 4'hE;
        step(6);
        chk(cpu_reset_o, 1'b0);
        for (int w = 0; w < 3; w++) begin
            src_reset(w);
        end
        results();
    end
endmodule
